// ---- rtl/gpt_pkg.sv ----
// Shared constants and types of the general purpose timer unit.
package gpt_pkg;

  localparam int GPT_NT = 5;
  localparam int GPT_NSRC = 6;
  localparam int GPT_DIV_W = 10;
  localparam int GPT_PRIO_W = 4;
  localparam logic [3:0] TIMER_BLOCK_ONE_PRESC_SHIFT = 4'h3;
  localparam logic [3:0] TIMER_BLOCK_TWO_PRESC_SHIFT = 4'h2;
  localparam logic [15:0] GPT_TMR_RESET = 16'h0000;
  localparam logic [15:0] GPT_CR_RESET = 16'h0000;
  localparam logic [GPT_DIV_W-1:0] GPT_DIV_RESET = 10'h000;

  // Timer slots: block one first, then block two.
  localparam int GPT_AUX_A = 0;
  localparam int GPT_CORE_ONE = 1;
  localparam int GPT_AUX_B = 2;
  localparam int GPT_AUX_C = 3;
  localparam int GPT_CORE_TWO = 4;
  localparam int GPT_SRC_CR = 5;

  // Pin slots on the synchroniser.
  localparam int GPT_PIN_DIR = 5;
  localparam int GPT_PIN_CAP = 10;
  localparam int GPT_PIN_N = 11;

  typedef enum logic [1:0] {
    GPT_MODE_TIMER = 2'b00,
    GPT_MODE_GATED = 2'b01,
    GPT_MODE_COUNTER = 2'b10,
    GPT_MODE_INCR = 2'b11
  } gpt_mode_type;

  typedef enum logic [1:0] {
    GPT_FUNC_TIMER = 2'b00,
    GPT_FUNC_CAPTURE = 2'b01,
    GPT_FUNC_RELOAD = 2'b10,
    GPT_FUNC_RSVD = 2'b11
  } gpt_func_type;

  typedef enum logic [1:0] {
    GPT_RLD_PIN = 2'b00,
    GPT_RLD_OTL_RISE = 2'b01,
    GPT_RLD_OTL_FALL = 2'b10,
    GPT_RLD_OTL_ANY = 2'b11
  } gpt_rld_type;

endpackage

// ---- rtl/gpt_pin_sync.sv ----
// Two-stage synchroniser with edge detection for the timer pins.
`timescale 1ns/1ps
module gpt_pin_sync #(
  parameter int W = 11
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_lvl,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  if (W < 1) begin : g_chk
    $error("gpt_pin_sync: W must be at least 1");
  end

  // The first stage feeds only the second; edges come from later stages.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_lvl = sync_q;
  assign o_rise = sync_q & ~prev_q;
  assign o_fall = ~sync_q & prev_q;
endmodule

// ---- rtl/gpt_timer.sv ----
// One up/down timer register with load, clear and wrap detection.
`timescale 1ns/1ps
module gpt_timer #(
  parameter int TW = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_cnt,
  input wire logic i_up,
  input wire logic i_load,
  input wire logic [TW-1:0] i_load_val,
  input wire logic i_clr,
  output logic [TW-1:0] o_val_q,
  output logic o_wrap
);
  import gpt_pkg::*;

  logic [TW-1:0] val_d;
  logic [TW-1:0] val_inc;
  logic [TW-1:0] val_dec;

  if (TW < 2 || TW > 16) begin : g_chk
    $error("gpt_timer: TW must lie between 2 and 16");
  end

  assign val_inc = o_val_q + TW'(1);
  assign val_dec = o_val_q - TW'(1);
  // A load wins over a clear, and both win over a count.
  assign val_d = i_load ? i_load_val :
                 i_clr ? '0 :
                 !i_cnt ? o_val_q :
                 i_up ? val_inc : val_dec;
  // Wrap ignores any load, so a reload can ride on the wrap it answers.
  assign o_wrap = i_cnt & (i_up ? &o_val_q : ~|o_val_q);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_val_q <= TW'(GPT_TMR_RESET);
    end else begin
      o_val_q <= val_d;
    end
  end
endmodule

// ---- rtl/gpt_unit.sv ----
// General purpose timer unit: two timer blocks with capture and reload.
`timescale 1ns/1ps
module gpt_unit #(
  parameter int TW = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Timer slots: 0 aux a, 1 core one, 2 aux b, 3 aux c, 4 core two.
  input wire logic [gpt_pkg::GPT_NT-1:0] i_run,
  input wire logic [2*gpt_pkg::GPT_NT-1:0] i_mode,
  input wire logic [3*gpt_pkg::GPT_NT-1:0] i_presc,
  input wire logic [gpt_pkg::GPT_NT-1:0] i_down,
  input wire logic [gpt_pkg::GPT_NT-1:0] i_dir_en,
  input wire logic [2*gpt_pkg::GPT_NT-1:0] i_edge,
  input wire logic [2:0] i_aux_otl,
  input wire logic [3:0] i_aux_func,
  input wire logic [3:0] i_rld_trig,
  input wire logic [gpt_pkg::GPT_NT-1:0] i_wr,
  input wire logic [TW-1:0] i_wdata,
  input wire logic [gpt_pkg::GPT_NT-1:0] i_timer_count_gate_pin,
  input wire logic [gpt_pkg::GPT_NT-1:0] i_timer_direction_pin,
  input wire logic i_capture_input_pin,
  input wire logic [1:0] i_cap_edge,
  input wire logic i_cap_clr,
  input wire logic i_cr_wr,
  input wire logic i_cr_reload_en,
  input wire logic [1:0] i_toggle_pin_en,
  input wire logic [gpt_pkg::GPT_NSRC-1:0] i_req_en,
  input wire logic [gpt_pkg::GPT_PRIO_W*gpt_pkg::GPT_NSRC-1:0] i_req_prio,
  input wire logic [gpt_pkg::GPT_NSRC-1:0] i_req_clr,
  output logic [gpt_pkg::GPT_NT*TW-1:0] o_timer_val,
  output logic [TW-1:0] o_capture_reload_reg,
  output logic o_core_one_toggle_latch,
  output logic o_core_two_toggle_latch,
  output logic o_core_one_toggle_pin,
  output logic o_core_two_toggle_pin,
  output logic [gpt_pkg::GPT_NSRC-1:0] o_req_flag,
  output logic o_irq,
  output logic [gpt_pkg::GPT_PRIO_W-1:0] o_irq_prio
);
  import gpt_pkg::*;

  if (TW < 2 || TW > 16) begin : g_chk
    $error("gpt_unit: TW must lie between 2 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic presc_tick(input logic [GPT_DIV_W-1:0] div,
                                      input logic [3:0] sh);
    logic [GPT_DIV_W:0] m;
    m = ((GPT_DIV_W+1)'(1) << sh) - (GPT_DIV_W+1)'(1);
    return &(div | ~m[GPT_DIV_W-1:0]);
  endfunction

  // Edge select code: bit 0 takes rising edges, bit 1 falling edges.
  function automatic logic edge_sel(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    return (sel[0] & rise) | (sel[1] & fall);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [GPT_DIV_W-1:0] div_q;
  logic [GPT_PIN_N-1:0] pin_lvl;
  logic [GPT_PIN_N-1:0] pin_rise;
  logic [GPT_PIN_N-1:0] pin_fall;
  logic [1:0] otl_q;
  logic [1:0] otl_d;
  logic [1:0] otl_rise;
  logic [1:0] otl_fall;
  logic [1:0] tpin_q;
  logic [GPT_NT-1:0] wrap;
  logic [GPT_NT-1:0] cnt_en;
  logic [GPT_NT-1:0] up;
  logic [GPT_NT-1:0] load;
  logic [GPT_NT-1:0] clr;
  logic [GPT_NT-1:0] hw_load;
  logic [GPT_NT-1:0] stop;
  logic [GPT_NT-1:0] use_otl;
  logic [TW-1:0] val [GPT_NT];
  logic [TW-1:0] hw_val [GPT_NT];
  logic [TW-1:0] cr_q;
  logic [GPT_NSRC-1:0] flag_q;
  logic [GPT_NSRC-1:0] flag_d;
  logic [GPT_NSRC-1:0] src_ev;
  logic [GPT_NSRC-1:0] pend;
  gpt_func_type func_a;
  gpt_func_type func_b;
  gpt_rld_type trig_a;
  gpt_rld_type trig_b;
  logic cap_a;
  logic cap_b;
  logic rld_a;
  logic rld_b;
  logic cap_c;
  logic core_two_rld;

  ////////////////////////////////////////////////////////////////////////////

  // One free running divider serves every prescaler setting.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      div_q <= GPT_DIV_RESET;
    end else begin
      div_q <= div_q + GPT_DIV_W'(1);
    end
  end

  gpt_pin_sync #(
    .W(GPT_PIN_N)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_pin({i_capture_input_pin, i_timer_direction_pin,
            i_timer_count_gate_pin}),
    .o_lvl(pin_lvl),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////

  // The latch changes only on a wrap, so its edges are known in that cycle.
  assign otl_d = otl_q ^ {wrap[GPT_CORE_TWO], wrap[GPT_CORE_ONE]};
  assign otl_rise = otl_d & ~otl_q;
  assign otl_fall = ~otl_d & otl_q;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      otl_q <= 2'b00;
      tpin_q <= 2'b00;
    end else begin
      otl_q <= otl_d;
      tpin_q <= otl_d & i_toggle_pin_en;
    end
  end

  assign o_core_one_toggle_latch = otl_q[0];
  assign o_core_two_toggle_latch = otl_q[1];
  assign o_core_one_toggle_pin = tpin_q[0];
  assign o_core_two_toggle_pin = tpin_q[1];

  ////////////////////////////////////////////////////////////////////////////

  assign func_a = gpt_func_type'(i_aux_func[1:0]);
  assign func_b = gpt_func_type'(i_aux_func[3:2]);
  assign trig_a = gpt_rld_type'(i_rld_trig[1:0]);
  assign trig_b = gpt_rld_type'(i_rld_trig[3:2]);

  assign stop[GPT_AUX_A] = func_a == GPT_FUNC_CAPTURE ||
                           func_a == GPT_FUNC_RELOAD;
  assign stop[GPT_AUX_B] = func_b == GPT_FUNC_CAPTURE ||
                           func_b == GPT_FUNC_RELOAD;
  assign stop[GPT_CORE_ONE] = 1'b0;
  assign stop[GPT_AUX_C] = 1'b0;
  assign stop[GPT_CORE_TWO] = 1'b0;

  // Aux timers may take the owning core latch as their count clock.
  assign use_otl = {1'b0, i_aux_otl[2], i_aux_otl[1], 1'b0, i_aux_otl[0]};

  for (genvar i = 0; i < GPT_NT; i++) begin : g_tmr
    localparam int K = (i < 3) ? 0 : 1;
    gpt_mode_type mode;
    logic [3:0] sh;
    logic tick;
    logic s_rise;
    logic s_fall;
    logic ev;
    logic q_ev;
    logic q_up;
    logic a_lvl;
    logic b_lvl;
    logic base_cnt;

    assign mode = gpt_mode_type'(i_mode[2*i +: 2]);
    assign sh = ((i < 3) ? TIMER_BLOCK_ONE_PRESC_SHIFT : TIMER_BLOCK_TWO_PRESC_SHIFT) +
                {1'b0, i_presc[3*i +: 3]};
    assign tick = presc_tick(div_q, sh);
    assign s_rise = use_otl[i] ? otl_rise[K] : pin_rise[i];
    assign s_fall = use_otl[i] ? otl_fall[K] : pin_fall[i];
    assign ev = edge_sel(i_edge[2*i +: 2], s_rise, s_fall);
    assign a_lvl = pin_lvl[i];
    assign b_lvl = pin_lvl[GPT_PIN_DIR+i];
    // Four counts per encoder cycle, direction from the phase order.
    assign q_ev = pin_rise[i] | pin_fall[i] | pin_rise[GPT_PIN_DIR+i] |
                  pin_fall[GPT_PIN_DIR+i];
    assign q_up = (pin_rise[i] & ~b_lvl) | (pin_fall[i] & b_lvl) |
                  (pin_rise[GPT_PIN_DIR+i] & a_lvl) |
                  (pin_fall[GPT_PIN_DIR+i] & ~a_lvl);
    // Block two has no encoder decoder; that mode code holds the timer.
    assign base_cnt = (mode == GPT_MODE_TIMER) ? tick :
                      (mode == GPT_MODE_GATED) ?
                        tick & (a_lvl == i_edge[2*i]) :
                      (mode == GPT_MODE_COUNTER) ? ev :
                      (i < 3) ? q_ev : 1'b0;
    assign cnt_en[i] = i_run[i] & ~stop[i] & base_cnt;
    assign up[i] = (mode == GPT_MODE_INCR) ? q_up ^ i_down[i] :
                   ~(i_down[i] ^ (i_dir_en[i] & b_lvl));
    assign load[i] = i_wr[i] | hw_load[i];
    assign o_timer_val[TW*i +: TW] = val[i];

    gpt_timer #(
      .TW(TW)
    ) u_tmr (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_cnt(cnt_en[i]),
      .i_up(up[i]),
      .i_load(load[i]),
      .i_load_val(i_wr[i] ? i_wdata : hw_val[i]),
      .i_clr(clr[i]),
      .o_val_q(val[i]),
      .o_wrap(wrap[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////

  assign cap_a = func_a == GPT_FUNC_CAPTURE &&
                 edge_sel(i_edge[1:0], pin_rise[0], pin_fall[0]);
  assign cap_b = func_b == GPT_FUNC_CAPTURE &&
                 edge_sel(i_edge[5:4], pin_rise[2], pin_fall[2]);
  assign rld_a = func_a == GPT_FUNC_RELOAD &&
                 (trig_a == GPT_RLD_PIN ?
                   edge_sel(i_edge[1:0], pin_rise[0], pin_fall[0]) :
                   edge_sel(i_rld_trig[1:0], otl_rise[0],
                            otl_fall[0]));
  assign rld_b = func_b == GPT_FUNC_RELOAD &&
                 (trig_b == GPT_RLD_PIN ?
                   edge_sel(i_edge[5:4], pin_rise[2], pin_fall[2]) :
                   edge_sel(i_rld_trig[3:2], otl_rise[0],
                            otl_fall[0]));
  assign cap_c = edge_sel(i_cap_edge, pin_rise[GPT_PIN_CAP],
                          pin_fall[GPT_PIN_CAP]);
  assign core_two_rld = wrap[GPT_CORE_TWO] & i_cr_reload_en;

  // Aux a has priority if both aux timers reload on the same edge.
  assign hw_load = {core_two_rld, 1'b0, cap_b, rld_a | rld_b, cap_a};
  assign hw_val[GPT_AUX_A] = val[GPT_CORE_ONE];
  assign hw_val[GPT_AUX_B] = val[GPT_CORE_ONE];
  assign hw_val[GPT_CORE_ONE] = rld_a ? val[GPT_AUX_A] :
                                val[GPT_AUX_B];
  assign hw_val[GPT_AUX_C] = '0;
  assign hw_val[GPT_CORE_TWO] = cr_q;
  assign clr = {1'b0, cap_c & i_cap_clr, 3'b000};

  // A capture wins over a software write in the same cycle.
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cr_q <= TW'(GPT_CR_RESET);
    end else if (cap_c) begin
      cr_q <= val[GPT_AUX_C];
    end else if (i_cr_wr) begin
      cr_q <= i_wdata;
    end
  end

  assign o_capture_reload_reg = cr_q;

  ////////////////////////////////////////////////////////////////////////////

  // Aux a and b also request on their capture or reload events.
  assign src_ev = {cap_c, wrap | {2'b00, cap_b | rld_b, 1'b0,
                                  cap_a | rld_a}};
  // Setting wins over clearing so no event is lost.
  assign flag_d = (flag_q & ~i_req_clr) | src_ev;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_req_flag = flag_q;
  assign pend = flag_q & i_req_en;
  assign o_irq = |pend;

  always_comb begin
    o_irq_prio = '0;
    for (int s = 0; s < GPT_NSRC; s++) begin
      if (pend[s] && i_req_prio[GPT_PRIO_W*s +: GPT_PRIO_W] > o_irq_prio) begin
        o_irq_prio = i_req_prio[GPT_PRIO_W*s +: GPT_PRIO_W];
      end
    end
  end
endmodule

// ---- bench/gpt_unit_properties.sv ----
// Concurrent checks on the ports of the general purpose timer unit.
`timescale 1ns/1ps
module gpt_unit_properties #(
  parameter int TW = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [4:0] i_run,
  input wire logic [9:0] i_mode,
  input wire logic [14:0] i_presc,
  input wire logic [4:0] i_wr,
  input wire logic [TW-1:0] i_wdata,
  input wire logic [1:0] i_toggle_pin_en,
  input wire logic [5:0] i_req_en,
  input wire logic [5:0] i_req_clr,
  input wire logic [5*TW-1:0] o_timer_val,
  input wire logic o_core_one_toggle_latch,
  input wire logic o_core_one_toggle_pin,
  input wire logic [5:0] o_req_flag,
  input wire logic o_irq
);
  logic [TW-1:0] c1;
  logic [TW-1:0] c2;
  assign c1 = o_timer_val[TW+:TW];
  assign c2 = o_timer_val[4*TW+:TW];
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  chk_wrap_toggles: assert property (
    (($past(c1) == '1 && c1 == '0) || ($past(c1) == '0 && c1 == '1))
    && !$past(i_wr[1]) |-> o_core_one_toggle_latch
    != $past(o_core_one_toggle_latch)) else $error("no toggle on wrap");
  chk_latch_cause: assert property (
    $changed(o_core_one_toggle_latch) |-> $past(c1) == '1 || $past(c1) == '0)
    else $error("latch toggled without a wrap");
  chk_pin_follow: assert property (
    o_core_one_toggle_pin == (o_core_one_toggle_latch &
    $past(i_toggle_pin_en[0]))) else $error("toggle pin differs");
  chk_flag_on_wrap: assert property (
    (($past(c1) == '1 && c1 == '0) || ($past(c1) == '0 && c1 == '1))
    && !$past(i_wr[1]) |=> o_req_flag[1]) else $error("wrap flag missing");
  chk_write_load: assert property (
    i_wr[4] |=> c2 == $past(i_wdata)) else $error("write not loaded");
  chk_flag_sticky: assert property (
    ($past(o_req_flag) & ~$past(i_req_clr) & ~o_req_flag) == 6'h00)
    else $error("flag dropped without clear");
  chk_irq_or: assert property (
    o_irq == |(o_req_flag & i_req_en)) else $error("irq mismatch");
  chk_stopped_holds: assert property (
    !i_run[4] && !$past(i_run[4]) && !i_wr[4] |=> $stable(c2))
    else $error("stopped timer moved");
  chk_presc_gap: assert property (
    $past(i_run[1]) && i_mode[3:2] == 2'b00 && i_presc[5:3] == 3'h0 &&
    $changed(c1) && !$past(i_wr[1]) |=> $stable(c1) [*7])
    else $error("prescaled tick too early");
endmodule

bind gpt_unit gpt_unit_properties #(.TW(TW)) u_props (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_run(i_run),
  .i_mode(i_mode), .i_presc(i_presc), .i_wr(i_wr), .i_wdata(i_wdata),
  .i_toggle_pin_en(i_toggle_pin_en), .i_req_en(i_req_en),
  .i_req_clr(i_req_clr), .o_timer_val(o_timer_val),
  .o_core_one_toggle_latch(o_core_one_toggle_latch),
  .o_core_one_toggle_pin(o_core_one_toggle_pin),
  .o_req_flag(o_req_flag), .o_irq(o_irq));

// ---- bench/gpt_pin_model.sv ----
// Pin-side model: count, gate, direction, encoder and capture signals.
`timescale 1ns/1ps
module gpt_pin_model (
  input wire logic i_core_clk,
  output logic [4:0] o_cnt_pin,
  output logic [4:0] o_dir_pin,
  output logic o_cap_pin
);
  logic [10:0] lvl = 11'h000;
  assign o_cnt_pin = lvl[4:0];
  assign o_dir_pin = lvl[9:5];
  assign o_cap_pin = lvl[10];
  // Every level is held at least two cycles so the synchroniser sees it.
  task automatic setp(input int s, input logic v, input int gap);
    lvl[s] = v;
    repeat (gap) @(negedge i_core_clk);
  endtask
  task automatic pulse(input int s, input int gap);
    setp(s, 1'b1, gap);
    setp(s, 1'b0, gap);
  endtask
  // Gray step on phases A (count pin) and B (direction pin).
  task automatic enc(input int s, input bit fwd, input int gap);
    if ((lvl[s] == lvl[s+5]) == fwd) setp(s, ~lvl[s], gap);
    else setp(s + 5, ~lvl[s+5], gap);
  endtask
endmodule

// ---- bench/gpt_unit_test.sv ----
// Self-checking bench for the general purpose timer unit.
`timescale 1ns/1ps
module gpt_unit_test;
  import gpt_pkg::*;
  typedef struct {int sel; logic [15:0] val;} gpt_note_type;
  logic clk = 0, rst = 1, cclr = 0, crw = 0, cre = 0;
  logic [4:0] run = '0, dn = '0, den = '0, wr = '0, cpin, dpin;
  logic [9:0] mode = '0, edg = '0;
  logic [14:0] presc = '0;
  logic [2:0] aotl = '0;
  logic [3:0] afn = '0, rtrg = '0, prio;
  logic [15:0] wd = '0, cr, rv;
  logic [1:0] cedge = '0, tpe = 2'b11;
  logic [5:0] ren = '0, rclr = '0, flag;
  logic [23:0] rprio = '0;
  logic [79:0] tv;
  logic l1, l2, p1, p2, irq, cap;
  int fail_count = 0, n_compared = 0, k;
  bit el1 = 0;
  gpt_note_type q[$];
  event smp;
  gpt_unit #(.TW(16)) u_dut (.i_core_clk(clk), .i_reset(rst), .i_run(run),
    .i_mode(mode), .i_presc(presc), .i_down(dn), .i_dir_en(den),
    .i_edge(edg), .i_aux_otl(aotl), .i_aux_func(afn), .i_rld_trig(rtrg),
    .i_wr(wr), .i_wdata(wd), .i_timer_count_gate_pin(cpin),
    .i_timer_direction_pin(dpin), .i_capture_input_pin(cap),
    .i_cap_edge(cedge), .i_cap_clr(cclr), .i_cr_wr(crw),
    .i_cr_reload_en(cre), .i_toggle_pin_en(tpe), .i_req_en(ren),
    .i_req_prio(rprio), .i_req_clr(rclr), .o_timer_val(tv),
    .o_capture_reload_reg(cr), .o_core_one_toggle_latch(l1),
    .o_core_two_toggle_latch(l2), .o_core_one_toggle_pin(p1),
    .o_core_two_toggle_pin(p2), .o_req_flag(flag), .o_irq(irq),
    .o_irq_prio(prio));
  gpt_pin_model u_pins (.i_core_clk(clk), .o_cnt_pin(cpin),
    .o_dir_pin(dpin), .o_cap_pin(cap));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] obs(input int s);
    case (s)
      5: return cr;
      6: return {14'h0, l2, l1};
      7: return {14'h0, p2, p1};
      8: return {10'h0, flag};
      9: return {11'h0, irq, prio};
      10: return {15'h0, tv[15:0] == 16'h0004 || tv[15:0] == 16'hfffc};
      default: return tv[16*s+:16];
    endcase
  endfunction
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  always @(smp) begin
    while (q.size() > 0) begin
      gpt_note_type n;
      n = q.pop_front();
      check($sformatf("output %0d", n.sel), obs(n.sel), n.val);
    end
  end
  task automatic note(input int s, input logic [15:0] v);
    q.push_back('{s, v});
    -> smp;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrt(input int s, input logic [15:0] v);
    wd = v;
    if (s == 5) crw = 1;
    else wr[s] = 1;
    tick(1);
    wr = '0;
    crw = 0;
    tick(1);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    $display("[ERR] run time expected end seen hang");
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    k = $urandom(37);
    tick(5);
    rst = 0;
    tick(2);
    for (int s = 0; s < 10; s++) note(s, 16'h0000);
    dn[1] = 1;
    // Any window of 2*factor cycles holds exactly two prescaler ticks.
    for (int s = 1; s < 5; s += 3) for (int c = 0; c < 8; c++) begin
      wrt(s, 16'h0000);
      presc[3*s+:3] = c[2:0];
      run[s] = 1;
      tick(2 << (c + (s == 1 ? 3 : 2)));
      run[s] = 0;
      tick(8);
      if (s == 1) el1 = ~el1;
      note(s, s == 1 ? 16'hfffe : 16'h0002);
      note(6, {15'h0, el1});
      note(7, {15'h0, el1});
    end
    mode[1:0] = 2'b10;
    edg[1:0] = 2'b01;
    run[0] = 1;
    k = 1 + $urandom % 4;
    for (int i = 0; i < k; i++) u_pins.pulse(0, 2 + $urandom % 4);
    tick(300);
    note(0, 16'(k));
    edg[1:0] = 2'b11;
    for (int i = 0; i < k; i++) u_pins.pulse(0, 2 + $urandom % 4);
    tick(4);
    note(0, 16'(3 * k));
    wrt(0, 16'h0000);
    mode[1:0] = 2'b11;
    for (int i = 0; i < 5; i++) u_pins.enc(0, 1, 3);
    for (int i = 0; i < 5; i++) u_pins.enc(0, 0, 3);
    tick(4);
    note(0, 16'h0000);
    for (int i = 0; i < 4; i++) u_pins.enc(0, 1, 2);
    tick(4);
    note(10, 16'h0001);
    mode[5:4] = 2'b01;
    edg[5:4] = 2'b01;
    run[2] = 1;
    tick(64);
    note(2, 16'h0000);
    u_pins.setp(2, 1'b1, 64);
    u_pins.setp(2, 1'b0, 8);
    note(2, 16'h0008);
    run[2] = 0;
    mode[5:4] = 2'b00;
    den[2] = 1;
    u_pins.setp(7, 1'b1, 5);
    run[2] = 1;
    tick(64);
    run[2] = 0;
    tick(2);
    note(2, 16'h0000);
    rv = 16'($urandom);
    wrt(1, rv);
    afn = 4'b0100;
    run[2] = 1;
    u_pins.pulse(2, 3);
    tick(64);
    note(2, rv);
    mode[1:0] = 2'b00;
    // The core has to count up to reach the wraps that fire the reloads.
    dn[1] = 0;
    afn = 4'b1010;
    rtrg = el1 ? 4'b0110 : 4'b1001;
    wrt(0, 16'hfffc);
    wrt(2, 16'hfffa);
    wrt(1, 16'hfffe);
    presc[5:3] = 3'h0;
    run[2:0] = 3'b111;
    tick(48);
    run = '0;
    tick(8);
    note(1, 16'hfffa);
    note(0, 16'hfffc);
    note(6, {15'h0, el1});
    cre = 1;
    wrt(5, 16'h0100);
    wrt(4, 16'hffff);
    mode[7:6] = 2'b10;
    aotl[2] = 1;
    // Fastest prescaler, so exactly one tick lands in the four-cycle run.
    presc[14:12] = 3'h0;
    tpe = 2'b01;
    edg[7:6] = 2'b11;
    run[4:3] = 2'b11;
    tick(4);
    run = '0;
    tick(4);
    note(4, 16'h0100);
    note(6, {14'h0, 1'b1, el1});
    note(7, {14'h0, 1'b0, el1});
    note(3, 16'h0001);
    wrt(3, 16'h0777);
    cedge = 2'b01;
    cclr = 1;
    u_pins.pulse(10, 3);
    tick(4);
    note(5, 16'h0777);
    note(3, 16'h0000);
    rv = 16'($urandom);
    wrt(1, rv);
    afn = 4'b1001;
    rtrg = 4'b0000;
    edg[1:0] = 2'b01;
    u_pins.pulse(0, 3);
    wrt(1, 16'h0000);
    u_pins.pulse(2, 3);
    tick(4);
    note(0, rv);
    note(1, 16'hfffa);
    mode[9:8] = 2'b11;
    run[4] = 1;
    tick(8);
    run = '0;
    tick(2);
    note(4, 16'h0100);
    note(8, 16'h0037);
    ren = 6'h32;
    rprio = 24'h390050;
    tick(1);
    note(9, 16'h0019);
    tick(1);
    ren = 6'h00;
    tick(1);
    note(9, 16'h0000);
    rclr = 6'h3f;
    tick(1);
    rclr = 6'h00;
    ren = 6'h32;
    tick(2);
    note(8, 16'h0000);
    note(9, 16'h0000);
    tick(2);
    report_and_stop();
  end
endmodule
